//--- rtl/afr_action.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// - low four control bits pick which port's acl table is reached
// - offset register selects entry byte, data register reads and writes it
// - remark priority is upper two bits joined with low bit of next byte
// - map mode 00 forwards with the lookup map only, reset value
// - map mode 01 forwards to entry map or lookup map
// - map mode 10 forwards to entry map and lookup map
// - map mode 11 replaces lookup map with entry map
// - port map bits 0,1,2,4 are ports 1 to 4, bit 3 reserved
// - in counter mode port map bit 4 picks microseconds or milliseconds
// - bit 3 clear: load 11-bit count, count down, interrupt on expiry
// - bit 3 set: count matched packets up, interrupt at the action value
// - upper eight cascade mask bits at offset 0x0C, reset zero
// - upper remark code 11 gives priority six or seven, by the low bit
// - remark enable replaces packet vlan priority, clear leaves it
module afr_action
  import afr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // packet decision input
  input  wire logic        pkt_valid,
  input  wire logic [1:0]  pkt_port,
  input  wire logic        pkt_match,
  input  wire logic [4:0]  pkt_lookup_map,
  input  wire logic [2:0]  pkt_vlan_prio,
  // packet decision output
  output logic             fwd_valid,
  output logic      [4:0]  fwd_map,
  output logic      [2:0]  fwd_prio,
  output logic             fwd_remarked,
  // cascade mask of the packet's port
  output logic      [7:0]  cascade_entry_mask_high,
  // interrupt
  output logic             irq
);

  // counter mode is decoded for the packet path and each counter
  function automatic logic afr_is_counter(input logic [3:0] cfg);
    afr_is_counter = (cfg[1:0] == AFR_MD_COUNTER) && (cfg[3:2] == AFR_ENB_COUNTER);
  endfunction

  // per-port acl storage
  logic [7:0]  action_high [AFR_NUM_PORTS];
  logic [7:0]  acl_action_remark_low_and_port_map [AFR_NUM_PORTS];
  logic [7:0]  acl_rule_set_mask_high [AFR_NUM_PORTS];

  logic [7:0]  ind_ctrl;
  logic [7:0]  ind_offset;
  logic [15:0] match_cfg;
  logic [3:0]  int_status;
  logic [3:0]  int_mask;

  // write channel holding
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // prescaler
  logic [7:0]  us_cnt;
  logic [9:0]  ms_cnt;
  logic        us_tick;
  logic        ms_tick;

  logic [CNT_W-1:0] cnt_value [AFR_NUM_PORTS];
  logic [3:0]       cnt_expire;
  logic [3:0]       cnt_load;

  // indirect decode
  wire  [2:0]  sel_table = ind_ctrl[AFR_TBL_MSB:AFR_TBL_LSB];
  wire  [3:0]  sel_port  = ind_ctrl[AFR_PORT_MSB:AFR_PORT_LSB];
  wire         sel_ok    = (sel_table == AFR_TBL_ACL) && (sel_port < 4'(AFR_NUM_PORTS));
  wire  [1:0]  sel_idx   = sel_port[1:0];
  wire         ofs_ahi   = sel_ok && (ind_offset == AFR_OFS_ACTION_HIGH);
  wire         ofs_rlpm  = sel_ok && (ind_offset == AFR_OFS_REMARK_PMAP);
  wire         ofs_casc  = sel_ok && (ind_offset == AFR_OFS_CASCADE_HIGH);

  // write decode
  wire         wr_go     = aw_held && w_held && !s_axi_bvalid;
  wire         wr_lane0  = w_strb[0];
  wire         wr_lane1  = w_strb[1];
  wire         wr_ctrl   = wr_go && (aw_addr == AFR_ADDR_IND_CTRL);
  wire         wr_ofs    = wr_go && (aw_addr == AFR_ADDR_IND_OFFSET);
  wire         wr_data   = wr_go && (aw_addr == AFR_ADDR_IND_DATA) && wr_lane0;
  wire         wr_stat   = wr_go && (aw_addr == AFR_ADDR_INT_STATUS);
  wire         wr_mask   = wr_go && (aw_addr == AFR_ADDR_INT_MASK);
  wire         wr_match  = wr_go && (aw_addr == AFR_ADDR_MATCH_CFG);
  wire         wr_known  = (aw_addr == AFR_ADDR_IND_CTRL) || (aw_addr == AFR_ADDR_IND_OFFSET) ||
                           (aw_addr == AFR_ADDR_IND_DATA) || (aw_addr == AFR_ADDR_INT_STATUS) ||
                           (aw_addr == AFR_ADDR_INT_MASK) || (aw_addr == AFR_ADDR_MATCH_CFG) ||
                           (aw_addr == AFR_ADDR_CNT_STATUS);

  // indirect read byte; unselected tables and offsets read zero
  wire  [7:0]  ind_rd_byte = ofs_ahi  ? action_high[sel_idx] :
                             ofs_rlpm ? acl_action_remark_low_and_port_map[sel_idx] :
                             ofs_casc ? acl_rule_set_mask_high[sel_idx] : 8'h00;

  wire  [31:0] rd_word   = (s_axi_araddr == AFR_ADDR_IND_CTRL)   ? {24'h000000, ind_ctrl} :
                           (s_axi_araddr == AFR_ADDR_IND_OFFSET) ? {24'h000000, ind_offset} :
                           (s_axi_araddr == AFR_ADDR_IND_DATA)   ? {24'h000000, ind_rd_byte} :
                           (s_axi_araddr == AFR_ADDR_INT_STATUS) ? {28'h0000000, int_status} :
                           (s_axi_araddr == AFR_ADDR_INT_MASK)   ? {28'h0000000, int_mask} :
                           (s_axi_araddr == AFR_ADDR_MATCH_CFG)  ? {16'h0000, match_cfg} :
                           (s_axi_araddr == AFR_ADDR_CNT_STATUS && sel_ok) ?
                             {21'h000000, cnt_value[sel_idx]} : 32'h00000000;
  wire         rd_known  = (s_axi_araddr == AFR_ADDR_IND_CTRL) || (s_axi_araddr == AFR_ADDR_IND_OFFSET) ||
                           (s_axi_araddr == AFR_ADDR_IND_DATA) || (s_axi_araddr == AFR_ADDR_INT_STATUS) ||
                           (s_axi_araddr == AFR_ADDR_INT_MASK) || (s_axi_araddr == AFR_ADDR_MATCH_CFG) ||
                           (s_axi_araddr == AFR_ADDR_CNT_STATUS);

  // handshakes: one write and one read in flight
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      else if (wr_go)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_go)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AFR_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? AFR_RESP_OKAY : AFR_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read data registered when the address is taken
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= AFR_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_known ? AFR_RESP_OKAY : AFR_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // direct control registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ind_ctrl   <= AFR_RST_BYTE;
      ind_offset <= AFR_RST_BYTE;
      int_mask   <= 4'h0;
      match_cfg  <= AFR_RST_MATCH;
    end
    else
    begin
      if (wr_ctrl && wr_lane0)
        ind_ctrl <= w_data[7:0];
      if (wr_ofs && wr_lane0)
        ind_offset <= w_data[7:0];
      if (wr_mask && wr_lane0)
        int_mask <= w_data[3:0];
      if (wr_match && wr_lane0)
        match_cfg[7:0] <= w_data[7:0];
      if (wr_match && wr_lane1)
        match_cfg[15:8] <= w_data[15:8];
    end
  end

  // per-port entry bytes and counters
  genvar p;
  generate
    for (p = 0; p < AFR_NUM_PORTS; p++)
    begin : g_port
      wire       hit_here  = wr_data && (sel_idx == 2'(p));
      wire [3:0] cfg       = match_cfg[4*p +: 4];
      wire [7:0] rlpm      = acl_action_remark_low_and_port_map[p];

      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          action_high[p]                        <= AFR_RST_BYTE;
          acl_action_remark_low_and_port_map[p] <= AFR_RST_BYTE;
          acl_rule_set_mask_high[p]             <= AFR_RST_CASCADE;
        end
        else
        begin
          if (hit_here && ofs_ahi)
            action_high[p] <= w_data[7:0];
          if (hit_here && ofs_rlpm)
            acl_action_remark_low_and_port_map[p] <= w_data[7:0];
          if (hit_here && ofs_casc)
            acl_rule_set_mask_high[p] <= w_data[7:0];
        end
      end

      // a change of action bits or match config re-arms the counter
      assign cnt_load[p] = (hit_here && (ofs_ahi || ofs_rlpm)) || wr_match;

      afr_counter u_counter (
        .clk      (clk),
        .rstn     (rstn),
        .active   (afr_is_counter(cfg)),
        .count_up (rlpm[AFR_UPDN_BIT]),
        .unit_ms  (rlpm[AFR_UNIT_BIT]),
        .load     (cnt_load[p]),
        .target   ({action_high[p], rlpm[7:5]}),
        .us_tick  (us_tick),
        .ms_tick  (ms_tick),
        .hit      (pkt_valid && pkt_match && (pkt_port == 2'(p))),
        .count    (cnt_value[p]),
        .expire   (cnt_expire[p])
      );
    end
  endgenerate

  // time base; one prescaler serves all four counters
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      us_cnt  <= 8'h00;
      ms_cnt  <= 10'h000;
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
    end
    else
    begin
      us_tick <= (us_cnt == 8'(US_CYCLES - 1));
      ms_tick <= (us_cnt == 8'(US_CYCLES - 1)) && (ms_cnt == 10'(MS_US - 1));
      if (us_cnt == 8'(US_CYCLES - 1))
      begin
        us_cnt <= 8'h00;
        ms_cnt <= (ms_cnt == 10'(MS_US - 1)) ? 10'h000 : ms_cnt + 10'h001;
      end
      else
        us_cnt <= us_cnt + 8'h01;
    end
  end

  // sticky status, set wins over the write-one clear
  wire [3:0] stat_clr = (wr_stat && wr_lane0) ? w_data[3:0] : 4'h0;

  always_ff @(posedge clk)
  begin
    if (!rstn)
      int_status <= 4'h0;
    else
      int_status <= (int_status & ~stat_clr) | cnt_expire;
  end

  assign irq = |(int_status & int_mask);

  // packet path: one cycle from pkt_valid to fwd_valid
  wire [7:0] p_ahi     = action_high[pkt_port];
  wire [7:0] p_rlpm    = acl_action_remark_low_and_port_map[pkt_port];
  wire       p_counter = afr_is_counter(match_cfg[4*pkt_port +: 4]);
  wire [4:0] p_entry   = p_rlpm[AFR_PMAP_MSB:AFR_PMAP_LSB] & AFR_PMAP_VALID;
  wire [1:0] p_mode    = p_rlpm[AFR_MM_MSB:AFR_MM_LSB];
  // upper code 00..11 forms priority bits 2:1, ahead of the low bit as bit 0
  wire [2:0] p_rprio   = {p_ahi[AFR_RPU_MSB:AFR_RPU_LSB], p_rlpm[AFR_RPL_BIT]};
  wire       p_apply   = pkt_match && !p_counter;
  wire       p_remark  = p_apply && p_ahi[AFR_RPE_BIT];

  wire [4:0] combined  = (p_mode == AFR_MM_OR)      ? (p_entry | pkt_lookup_map) :
                         (p_mode == AFR_MM_AND)     ? (p_entry & pkt_lookup_map) :
                         (p_mode == AFR_MM_REPLACE) ? p_entry : pkt_lookup_map;
  wire [4:0] next_map  = p_apply ? combined : pkt_lookup_map;
  wire [2:0] next_prio = p_remark ? p_rprio : pkt_vlan_prio;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      fwd_valid               <= 1'b0;
      fwd_map                 <= 5'h00;
      fwd_prio                <= 3'h0;
      fwd_remarked            <= 1'b0;
      cascade_entry_mask_high <= AFR_RST_CASCADE;
    end
    else
    begin
      fwd_valid               <= pkt_valid;
      fwd_map                 <= next_map;
      fwd_prio                <= next_prio;
      fwd_remarked            <= pkt_valid && p_remark;
      cascade_entry_mask_high <= acl_rule_set_mask_high[pkt_port];
    end
  end

endmodule

//--- rtl/afr_counter.sv
`timescale 1ns/1ps
module afr_counter
  import afr_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // control
  input  wire logic             active,
  input  wire logic             count_up,
  input  wire logic             unit_ms,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] target,
  // events
  input  wire logic             us_tick,
  input  wire logic             ms_tick,
  input  wire logic             hit,
  // state
  output logic      [CNT_W-1:0] count,
  output logic                  expire
);

  logic             done;
  logic [CNT_W-1:0] next_count;
  logic             next_done;
  logic             next_expire;
  wire              tick = unit_ms ? ms_tick : us_tick;

  always_comb
  begin
    next_count  = count;
    next_done   = done;
    next_expire = 1'b0;
    if (load)
    begin
      // rewrite of the action bits re-arms the counter
      next_count = count_up ? '0 : target;
      next_done  = 1'b0;
    end
    else if (active && !done)
    begin
      if (count_up)
      begin
        if (count == target)
        begin
          next_expire = 1'b1;
          next_done   = 1'b1;
        end
        else if (hit)
          next_count = count + 1'b1;
      end
      else if (tick)
      begin
        if (count == '0)
        begin
          next_expire = 1'b1;
          next_done   = 1'b1;
        end
        else
          next_count = count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      count  <= '0;
      done   <= 1'b0;
      expire <= 1'b0;
    end
    else
    begin
      count  <= next_count;
      done   <= next_done;
      expire <= next_expire;
    end
  end

endmodule

//--- rtl/afr_pkg.sv
package afr_pkg;

  // axi4-lite register byte addresses
  localparam logic [7:0] AFR_ADDR_IND_CTRL   = 8'h00;
  localparam logic [7:0] AFR_ADDR_IND_OFFSET = 8'h04;
  localparam logic [7:0] AFR_ADDR_IND_DATA   = 8'h08;
  localparam logic [7:0] AFR_ADDR_INT_STATUS = 8'h0C;
  localparam logic [7:0] AFR_ADDR_INT_MASK   = 8'h10;
  localparam logic [7:0] AFR_ADDR_MATCH_CFG  = 8'h14;
  localparam logic [7:0] AFR_ADDR_CNT_STATUS = 8'h18;

  // indirect control fields
  localparam int         AFR_TBL_MSB   = 7;
  localparam int         AFR_TBL_LSB   = 5;
  localparam int         AFR_PORT_MSB  = 3;
  localparam int         AFR_PORT_LSB  = 0;
  localparam logic [2:0] AFR_TBL_ACL   = 3'h2;
  localparam int         AFR_NUM_PORTS = 4;

  // offsets inside one acl entry
  localparam logic [7:0] AFR_OFS_ACTION_HIGH  = 8'h0A;
  localparam logic [7:0] AFR_OFS_REMARK_PMAP  = 8'h0B;
  localparam logic [7:0] AFR_OFS_CASCADE_HIGH = 8'h0C;

  // action high byte fields
  localparam int AFR_RPE_BIT   = 2;
  localparam int AFR_RPU_MSB   = 1;
  localparam int AFR_RPU_LSB   = 0;
  // remark / port map byte fields
  localparam int AFR_RPL_BIT   = 7;
  localparam int AFR_MM_MSB    = 6;
  localparam int AFR_MM_LSB    = 5;
  localparam int AFR_PMAP_MSB  = 4;
  localparam int AFR_PMAP_LSB  = 0;
  localparam int AFR_UNIT_BIT  = 4;
  localparam int AFR_UPDN_BIT  = 3;
  localparam logic [4:0] AFR_PMAP_VALID = 5'h17;

  // match config nibble per port: [1:0] match type, [3:2] enable code
  localparam logic [1:0] AFR_MD_COUNTER  = 2'h1;
  localparam logic [1:0] AFR_ENB_COUNTER = 2'h0;

  // reset values
  localparam logic [7:0] AFR_RST_BYTE     = 8'h00;
  localparam logic [7:0] AFR_RST_CASCADE  = 8'h00;
  localparam logic [15:0] AFR_RST_MATCH   = 16'h0000;

  // map combine modes
  localparam logic [1:0] AFR_MM_LOOKUP  = 2'h0;
  localparam logic [1:0] AFR_MM_OR      = 2'h1;
  localparam logic [1:0] AFR_MM_AND     = 2'h2;
  localparam logic [1:0] AFR_MM_REPLACE = 2'h3;

  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int US_NS         = 1000;
  localparam int US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_US         = 1000;

  localparam int CNT_W = 11;

  localparam logic [1:0] AFR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] AFR_RESP_SLVERR = 2'h2;

endpackage

//--- tb/afr_action_asserts.sv
`timescale 1ns/1ps
module afr_action_asserts
  import afr_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // read channel
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // packet path
  input wire logic        pkt_valid,
  input wire logic        pkt_match,
  input wire logic [4:0]  pkt_lookup_map,
  input wire logic [2:0]  pkt_vlan_prio,
  input wire logic        fwd_valid,
  input wire logic [4:0]  fwd_map,
  input wire logic [2:0]  fwd_prio,
  input wire logic        fwd_remarked,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_fwd_on; pkt_valid |=> fwd_valid; endproperty
  property p_fwd_off; !pkt_valid |=> !fwd_valid; endproperty
  property p_miss; pkt_valid && !pkt_match |=> fwd_map == $past(pkt_lookup_map) && !fwd_remarked; endproperty
  property p_rsvd; pkt_valid |=> (fwd_map & ~($past(pkt_lookup_map) | AFR_PMAP_VALID)) == 5'h00; endproperty
  property p_keep; fwd_valid && !fwd_remarked |-> fwd_prio == $past(pkt_vlan_prio); endproperty
  property p_rmk; fwd_remarked |-> fwd_valid && $past(pkt_match); endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_arref; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_rwide; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_fwd_on: assert property (p_fwd_on) else $error("packet not answered");
  a_fwd_off: assert property (p_fwd_off) else $error("answer without packet");
  a_miss: assert property (p_miss) else $error("unmatched packet altered");
  a_rsvd: assert property (p_rsvd) else $error("reserved or foreign port in map");
  a_keep: assert property (p_keep) else $error("priority changed unremarked");
  a_rmk: assert property (p_rmk) else $error("remark without match");
  a_rhold: assert property (p_rhold) else $error("read data not held");
  a_arref: assert property (p_arref) else $error("taken read not answered");
  a_rwide: assert property (p_rwide) else $error("read upper bits set");
  c_irq: cover property ($rose(irq));
  c_rmk: cover property (fwd_remarked);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind afr_action afr_action_asserts u_asserts (.*);

//--- tb/afr_host.sv
`timescale 1ns/1ps
module afr_host
  import afr_pkg::*;
(
  // clock
  input  wire logic        clk,
  // write channels
  output logic      [7:0]  s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // read channels
  output logic      [7:0]  s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  // a bounded wait ran out
  output logic             hang
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, hang} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 200);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 200) hang <= 1'b1;
    #1;
  endtask
  // slow reader: ready only after data shows, so the hold is exercised
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 200);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 200) hang <= 1'b1;
    #1;
  endtask
  task automatic sel(input logic [1:0] p, input logic [7:0] o);
    logic [1:0] r;
    wr(AFR_ADDR_IND_CTRL, {24'h0, AFR_TBL_ACL, 3'h0, p}, r);
    wr(AFR_ADDR_IND_OFFSET, {24'h0, o}, r);
  endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import afr_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, cascade_entry_mask_high;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hang, fwd_valid, fwd_remarked, irq;
  logic        pkt_valid = 1'b0;
  logic        pkt_match = 1'b0;
  logic [1:0]  pkt_port = 2'h0;
  logic [4:0]  pkt_lookup_map = 5'h00;
  logic [2:0]  pkt_vlan_prio = 3'h0;
  logic [4:0]  fwd_map;
  logic [2:0]  fwd_prio;
  logic [4:0]  mexp [4] = '{5'h0C, 5'h1F, 5'h04, 5'h17};
  int          fail_count = 0;
  int          checks = 0;
  afr_action DUT (.*);
  afr_host host (.*);
  always #2.5 clk = ~clk;
  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    host.rd(a, rd_d, rsp);
    chk({30'h0, rsp}, {30'h0, AFR_RESP_OKAY}, what);
    chk(rd_d, exp, what);
  endtask
  task automatic ent_wr(input logic [1:0] p, input logic [7:0] o, input logic [7:0] d);
    host.sel(p, o);
    host.wr(AFR_ADDR_IND_DATA, {24'h0, d}, rsp);
  endtask
  task automatic ent_rd(input logic [1:0] p, input logic [7:0] o, input logic [7:0] exp, input string what);
    host.sel(p, o);
    reg_rd(AFR_ADDR_IND_DATA, {24'h0, exp}, what);
  endtask
  task automatic send(input logic [1:0] p, input logic m, input logic [4:0] lk, input logic [2:0] pr);
    @(posedge clk);
    pkt_port <= p;
    pkt_match <= m;
    pkt_lookup_map <= lk;
    pkt_vlan_prio <= pr;
    pkt_valid <= 1'b1;
    @(posedge clk);
    pkt_valid <= 1'b0;
    #1;
  endtask
  task automatic wait_irq(input int lim);
    int n;
    for (n = 0; n < lim && irq !== 1'b1; n++) @(posedge clk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    if (irq !== 1'b1) summarize();
  endtask
  always @(posedge hang)
  begin
    fail_count++;
    $display("[FAIL] %0t bus wait ran out", $time);
    summarize();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int p = 0; p < AFR_NUM_PORTS; p++)
    begin
      ent_rd(p[1:0], AFR_OFS_CASCADE_HIGH, AFR_RST_CASCADE, "cascade reset");
      ent_rd(p[1:0], AFR_OFS_REMARK_PMAP, AFR_RST_BYTE, "map byte reset");
    end
    host.rd(8'hFC, rd_d, rsp);
    chk({30'h0, rsp}, {30'h0, AFR_RESP_SLVERR}, "unmapped read");
    host.wr(8'hFC, 32'h0000_00FF, rsp);
    chk({30'h0, rsp}, {30'h0, AFR_RESP_SLVERR}, "unmapped write");
    // another table code: the window must not reach acl storage
    host.wr(AFR_ADDR_IND_CTRL, 32'h0000_0020, rsp);
    host.wr(AFR_ADDR_IND_OFFSET, {24'h0, AFR_OFS_CASCADE_HIGH}, rsp);
    host.wr(AFR_ADDR_IND_DATA, 32'h0000_005A, rsp);
    ent_rd(2'h0, AFR_OFS_CASCADE_HIGH, 8'h00, "foreign table");
    $display("test registers done");
    for (int m = 0; m < 4; m++)
    begin
      ent_wr(2'h1, AFR_OFS_REMARK_PMAP, {1'b0, m[1:0], 5'h1F});
      send(2'h1, 1'b1, 5'h0C, 3'h5);
      chk({27'h0, fwd_map}, {27'h0, mexp[m]}, "map mode");
    end
    send(2'h1, 1'b0, 5'h0A, 3'h2);
    chk({27'h0, fwd_map}, 32'h0A, "unmatched map");
    $display("test map modes done");
    for (int c = 0; c < 4; c++)
    begin
      ent_wr(2'h2, AFR_OFS_ACTION_HIGH, {6'h01, c[1:0]});
      ent_wr(2'h2, AFR_OFS_REMARK_PMAP, {~c[0], 7'h00});
      send(2'h2, 1'b1, 5'h01, 3'h0);
      chk({29'h0, fwd_prio}, {29'h0, c[1:0], ~c[0]}, "remark prio");
      chk({31'h0, fwd_remarked}, 32'h1, "remark flag");
    end
    ent_wr(2'h2, AFR_OFS_ACTION_HIGH, 8'h03);
    send(2'h2, 1'b1, 5'h01, 3'h6);
    chk({28'h0, fwd_remarked, fwd_prio}, 32'h6, "remark off");
    $display("test remark done");
    ent_wr(2'h2, AFR_OFS_CASCADE_HIGH, 8'hA5);
    ent_rd(2'h2, AFR_OFS_CASCADE_HIGH, 8'hA5, "cascade readback");
    send(2'h2, 1'b0, 5'h00, 3'h0);
    chk({24'h0, cascade_entry_mask_high}, 32'hA5, "cascade out");
    send(2'h3, 1'b0, 5'h00, 3'h0);
    chk({24'h0, cascade_entry_mask_high}, 32'h00, "cascade other port");
    $display("test cascade done");
    // count up to 3 on port 1
    host.wr(AFR_ADDR_INT_MASK, 32'h0000_000F, rsp);
    ent_wr(2'h0, AFR_OFS_ACTION_HIGH, 8'h00);
    ent_wr(2'h0, AFR_OFS_REMARK_PMAP, 8'h68);
    host.wr(AFR_ADDR_MATCH_CFG, 32'h0000_0001, rsp);
    repeat (2) send(2'h0, 1'b1, 5'h01, 3'h0);
    repeat (3) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0, "irq early");
    send(2'h0, 1'b1, 5'h01, 3'h0);
    wait_irq(10);
    reg_rd(AFR_ADDR_CNT_STATUS, 32'd3, "up count");
    send(2'h0, 1'b1, 5'h01, 3'h0);
    reg_rd(AFR_ADDR_CNT_STATUS, 32'd3, "count held");
    reg_rd(AFR_ADDR_INT_STATUS, 32'h1, "status set");
    host.wr(AFR_ADDR_INT_MASK, 32'h0000_0000, rsp);
    chk({31'h0, irq}, 32'h0, "irq masked");
    host.wr(AFR_ADDR_INT_MASK, 32'h0000_000F, rsp);
    host.wr(AFR_ADDR_INT_STATUS, 32'h0000_0001, rsp);
    send(2'h0, 1'b1, 5'h01, 3'h0);
    repeat (3) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0, "no second fire");
    $display("test count up done");
    // count down from 2 in microseconds on port 4
    ent_wr(2'h3, AFR_OFS_ACTION_HIGH, 8'h00);
    ent_wr(2'h3, AFR_OFS_REMARK_PMAP, 8'h40);
    host.wr(AFR_ADDR_MATCH_CFG, 32'h0000_1001, rsp);
    repeat (300) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0, "down early");
    wait_irq(800);
    reg_rd(AFR_ADDR_INT_STATUS, 32'h8, "down status");
    reg_rd(AFR_ADDR_CNT_STATUS, 32'h0, "down count");
    host.wr(AFR_ADDR_INT_STATUS, 32'h0000_0008, rsp);
    ent_wr(2'h3, AFR_OFS_REMARK_PMAP, 8'h10);
    repeat (1000) @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0, "millisecond unit");
    $display("test count down done");
    summarize();
  end
endmodule
